// >>> dac_host_pkg.sv
/*
 * Shared constants and types for the host side controller of a double
 * buffered 12-bit converter latch interface.
 * Assumes a 40 MHz system clock and that the converter pins are driven
 * straight from this controller with no extra glue logic.
 */
package dac_host_pkg;

    localparam int WORD_W = 12;
    localparam int TIMER_W = 3;

    // clock and pin timing, minimum times in ns
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_DATA_SETUP_NS = 50;
    localparam int T_ADDR_SETUP_NS = 100;
    localparam int T_CS_PULSE_NS = 100;
    localparam int T_DATA_HOLD_NS = 0;

    localparam int DATA_SETUP_CYC = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_SETUP_CYC = (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC = (T_CS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_LOW_RAW = (PULSE_CYC > ADDR_SETUP_CYC) ?
                                ((PULSE_CYC > DATA_SETUP_CYC) ? PULSE_CYC : DATA_SETUP_CYC) :
                                ((ADDR_SETUP_CYC > DATA_SETUP_CYC) ? ADDR_SETUP_CYC :
                                 DATA_SETUP_CYC);
    localparam int CS_LOW_CYC = (CS_LOW_RAW < 1) ? 1 : CS_LOW_RAW;
    localparam int HOLD_RAW = (T_DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
    localparam logic [TIMER_W-1:0] CS_LOAD_VAL = TIMER_W'(CS_LOW_CYC - 1);

    // reset values
    localparam logic [WORD_W-1:0] WORD_RST = 12'h000;
    localparam logic [1:0] STEP_RST = 2'h0;
    localparam logic [TIMER_W-1:0] TIMER_RST = 3'h0;

    typedef enum logic [1:0] {
        MODE_NIBBLE = 2'b00,
        MODE_BYTE = 2'b01,
        MODE_WORD = 2'b10
    } mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STROBE = 2'b01,
        ST_HOLD = 2'b10
    } state_t;

    typedef struct packed {
        logic second_rank_load_n;
        logic high_nibble_select_n;
        logic mid_nibble_select_n;
        logic low_nibble_select_n;
    } sel_lines_t;

    localparam sel_lines_t SEL_NONE = 4'hF;
    localparam sel_lines_t SEL_LOW = 4'hE;
    localparam sel_lines_t SEL_MID = 4'hD;
    localparam sel_lines_t SEL_HIGH = 4'hB;
    localparam sel_lines_t SEL_LOAD = 4'h7;
    localparam sel_lines_t SEL_LOW_MID = 4'hC;
    localparam sel_lines_t SEL_HIGH_LOAD = 4'h3;
    localparam sel_lines_t SEL_ALL = 4'h0;

    typedef struct packed {
        sel_lines_t sel;
        logic last;
    } step_t;

    typedef struct packed {
        state_t state;
        mode_t mode;
        logic [1:0] step;
        logic [WORD_W-1:0] word;
        logic cs_n;
        sel_lines_t sel;
        logic busy;
        logic done;
    } host_state_t;

    typedef struct packed {
        logic [TIMER_W-1:0] count;
    } timer_state_t;

endpackage : dac_host_pkg

// >>> dac_latch_host.sv
/*
 * Host controller that writes 12-bit words into a double buffered
 * converter latch through chip select and four latch select pins.
 * Assumes the converter pins are wired straight to the outputs and that
 * the user side logic runs on the same 40 MHz clock.
 */
`timescale 1ns/1ps
module dac_latch_host (
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic i_start,
    input wire logic [dac_host_pkg::WORD_W-1:0] i_word,
    input wire dac_host_pkg::mode_t i_mode,
    input wire logic i_twos_comp,
    output logic o_busy,
    output logic o_done,
    output logic [dac_host_pkg::WORD_W-1:0] o_data,
    output logic o_cs_n,
    output dac_host_pkg::sel_lines_t o_latch_sel
);
    import dac_host_pkg::*;

    host_state_t s_r;
    host_state_t s_nxt;
    logic tmr_load;
    logic tmr_zero;
    step_t cur_step;
    step_t nxt_step;

    // selects for each strobe of a transfer, per bus width
    function automatic step_t step_of(input mode_t mode, input logic [1:0] idx);
        step_t st;
        st = '{sel: SEL_ALL, last: 1'b1};
        case (mode)
            // one latch per strobe, load last
            MODE_NIBBLE: begin
                case (idx)
                    2'h0: st = '{sel: SEL_LOW, last: 1'b0};
                    2'h1: st = '{sel: SEL_MID, last: 1'b0};
                    2'h2: st = '{sel: SEL_HIGH, last: 1'b0};
                    default: st = '{sel: SEL_LOAD, last: 1'b1};
                endcase
            end
            MODE_BYTE: begin
                if (idx == 2'h0) begin
                    st = '{sel: SEL_LOW_MID, last: 1'b0};
                end else begin
                    st = '{sel: SEL_HIGH_LOAD, last: 1'b1};
                end
            end
            default: st = '{sel: SEL_ALL, last: 1'b1};
        endcase
        return st;
    endfunction : step_of

    dac_strobe_timer u_timer (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .i_load(tmr_load),
        .i_value(CS_LOAD_VAL),
        .o_zero(tmr_zero)
    );

    always_comb begin
        s_nxt = s_r;
        tmr_load = 1'b0;
        s_nxt.done = 1'b0;
        cur_step = step_of(s_r.mode, s_r.step);
        nxt_step = step_of(s_r.mode, s_r.step + 2'h1);
        case (s_r.state)
            ST_IDLE: begin
                s_nxt.cs_n = 1'b1;
                s_nxt.sel = SEL_NONE;
                if (i_start) begin
                    s_nxt.mode = (i_mode == MODE_NIBBLE || i_mode == MODE_BYTE) ?
                                 i_mode : MODE_WORD;
                    s_nxt.word = i_word;
                    s_nxt.word[WORD_W-1] = i_word[WORD_W-1] ^ i_twos_comp;
                    s_nxt.step = STEP_RST;
                    s_nxt.busy = 1'b1;
                    s_nxt.state = ST_HOLD;
                end
            end
            ST_STROBE: begin
                if (tmr_zero) begin
                    s_nxt.cs_n = 1'b1;
                    s_nxt.state = ST_HOLD;
                end
            end
            default: begin
                // hold: cs is high, data and selects stay one more cycle
                if (s_r.cs_n && s_r.sel != SEL_NONE && cur_step.last) begin
                    s_nxt.sel = SEL_NONE;
                    s_nxt.busy = 1'b0;
                    s_nxt.done = 1'b1;
                    s_nxt.state = ST_IDLE;
                end else begin
                    if (s_r.sel != SEL_NONE) begin
                        s_nxt.step = s_r.step + 2'h1;
                        s_nxt.sel = nxt_step.sel;
                    end else begin
                        s_nxt.sel = cur_step.sel;
                    end
                    s_nxt.cs_n = 1'b0;
                    tmr_load = 1'b1;
                    s_nxt.state = ST_STROBE;
                end
            end
        endcase
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            s_r <= '{state: ST_IDLE, mode: MODE_NIBBLE, step: STEP_RST, word: WORD_RST,
                     cs_n: 1'b1, sel: SEL_NONE, busy: 1'b0, done: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_busy = s_r.busy;
    assign o_done = s_r.done;
    assign o_data = s_r.word;
    assign o_cs_n = s_r.cs_n;
    assign o_latch_sel = s_r.sel;

    sequence seq_strobe(sel_lines_t v);
        $fell(s_r.cs_n) && (s_r.sel == v);
    endsequence

    a_cs_pulse_width: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        $fell(s_r.cs_n) |-> (!s_r.cs_n) [*4] ##1 s_r.cs_n)
        else $error("chip select pulse not four cycles");

    a_sel_stable_cs: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (!s_r.cs_n && !$past(s_r.cs_n)) |-> ($stable(s_r.sel) && $stable(s_r.word)))
        else $error("selects or data moved while chip select low");

    a_msb_invert: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (i_start && s_r.state == ST_IDLE) |=>
        (o_data == {$past(i_word[WORD_W-1]) ^ $past(i_twos_comp), $past(i_word[WORD_W-2:0])}))
        else $error("top data bit coding wrong");

    a_mid_after_low: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (seq_strobe(SEL_LOW) and (s_r.mode == MODE_NIBBLE)) |-> ##5 seq_strobe(SEL_MID))
        else $error("middle nibble strobe did not follow low nibble");

    a_high_after_mid: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (seq_strobe(SEL_MID) and (s_r.mode == MODE_NIBBLE)) |-> ##5 seq_strobe(SEL_HIGH))
        else $error("high nibble strobe did not follow middle nibble");

    a_load_ends_word: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        ($fell(s_r.cs_n) && !s_r.sel.second_rank_load_n) |-> ##5 (s_r.done && !s_r.busy))
        else $error("second rank load not followed by done");

    a_idle_quiet: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (!s_r.busy) |-> (s_r.cs_n && s_r.sel == SEL_NONE))
        else $error("pins active while idle");

    sequence seq_accept(mode_t m);
        $rose(s_r.busy) && (s_r.mode == m);
    endsequence

    a_word_span: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        seq_accept(MODE_WORD) |-> ##6 s_r.done)
        else $error("word transfer did not end after six cycles");

    a_byte_span: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        seq_accept(MODE_BYTE) |-> ##11 s_r.done)
        else $error("byte transfer did not end after eleven cycles");

    a_nibble_span: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        seq_accept(MODE_NIBBLE) |-> ##21 s_r.done)
        else $error("nibble transfer did not end after twenty one cycles");

    a_first_low_strobe: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        seq_accept(MODE_NIBBLE) |=> seq_strobe(SEL_LOW))
        else $error("nibble transfer did not open low nibble first");

    a_byte_pairing: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (seq_strobe(SEL_LOW_MID) and (s_r.mode == MODE_BYTE)) |-> ##5 seq_strobe(SEL_HIGH_LOAD))
        else $error("byte transfer strobes out of order");

    a_word_all_open: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        ($fell(s_r.cs_n) && (s_r.mode == MODE_WORD)) |-> (s_r.sel == SEL_ALL))
        else $error("word transfer did not open every latch");

    a_start_opens_cs: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        $rose(s_r.busy) |=> $fell(s_r.cs_n))
        else $error("chip select did not fall after accept");

    a_cs_low_sel: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (!s_r.cs_n) |-> (s_r.sel != SEL_NONE))
        else $error("chip select low with no latch selected");

    a_sel_hold_after: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        $rose(s_r.cs_n) |-> ($stable(s_r.sel) && $stable(s_r.word)))
        else $error("selects or data moved as chip select rose");

    a_load_last_step: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        (!s_r.cs_n && !s_r.sel.second_rank_load_n) |-> cur_step.last)
        else $error("second rank loaded before the last strobe");

    a_done_one_cycle: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
        s_r.done |=> !s_r.done)
        else $error("done pulse longer than one cycle");

endmodule : dac_latch_host

// >>> dac_latch_model.sv
/*
 * Behavioural model of the double buffered converter latch pair.
 * Assumes pins come straight from the host controller, no glue.
 */
`timescale 1ns/1ps
module dac_latch_model (
    input wire logic i_cs_n,
    input wire dac_host_pkg::sel_lines_t i_sel,
    input wire logic [dac_host_pkg::WORD_W-1:0] i_data,
    output logic [dac_host_pkg::WORD_W-1:0] o_out
);
    import dac_host_pkg::*;
    logic [3:0] rank_lo;
    logic [3:0] rank_mid;
    logic [3:0] rank_hi;
    always_latch begin
        if (!i_cs_n && !i_sel.low_nibble_select_n) rank_lo = i_data[3:0];
    end
    always_latch begin
        if (!i_cs_n && !i_sel.mid_nibble_select_n) rank_mid = i_data[7:4];
    end
    always_latch begin
        if (!i_cs_n && !i_sel.high_nibble_select_n) rank_hi = i_data[11:8];
    end
    // codes pass to output only on load
    always_latch begin
        if (!i_cs_n && !i_sel.second_rank_load_n) o_out = {rank_hi, rank_mid, rank_lo};
    end
endmodule : dac_latch_model

// >>> dac_strobe_timer.sv
/*
 * Down counter that times the chip select low phase.
 * Assumes a synchronous load from logic on the same clock.
 */
`timescale 1ns/1ps
module dac_strobe_timer (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic [dac_host_pkg::TIMER_W-1:0] i_value,
    output logic o_zero
);
    import dac_host_pkg::*;

    timer_state_t t_r;
    timer_state_t t_nxt;

    always_comb begin
        t_nxt = t_r;
        if (i_load) begin
            t_nxt.count = i_value;
        end else if (t_r.count != TIMER_RST) begin
            t_nxt.count = t_r.count - TIMER_W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            t_r <= '{count: TIMER_RST};
        end else begin
            t_r <= t_nxt;
        end
    end

    assign o_zero = (t_r.count == TIMER_RST);

endmodule : dac_strobe_timer

// >>> double_buffered_dac_latch_tb.sv
/*
 * Self-checking bench for the latch host controller with a latch model.
 * Assumes one 40 MHz clock and the package constants of the design.
 */
`timescale 1ns/1ps
module double_buffered_dac_latch_tb;
    import dac_host_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic [WORD_W-1:0] word = 12'h000;
    mode_t mode = MODE_WORD;
    logic tc = 1'b0;
    logic busy, done, cs_n;
    logic [WORD_W-1:0] data, dac_out;
    sel_lines_t sel;
    int miscompares = 0;
    int tests_run = 0;
    int seed = 41303;
    int r;
    always #12.5 clk = ~clk;
    dac_latch_host dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .i_start(start), .i_word(word),
        .i_mode(mode), .i_twos_comp(tc), .o_busy(busy), .o_done(done), .o_data(data),
        .o_cs_n(cs_n), .o_latch_sel(sel));
    dac_latch_model device (.i_cs_n(cs_n), .i_sel(sel), .i_data(data), .o_out(dac_out));
    function automatic logic [WORD_W-1:0] exp_val(input logic [WORD_W-1:0] w, input logic t);
        return t ? {~w[11], w[10:0]} : w;
    endfunction : exp_val
    function automatic sel_lines_t exp_sel(input logic [1:0] m, input int n);
        if (m == 2'b00) return (n == 0) ? SEL_LOW : (n == 1) ? SEL_MID :
            (n == 2) ? SEL_HIGH : SEL_LOAD;
        if (m == 2'b01) return (n == 0) ? SEL_LOW_MID : SEL_HIGH_LOAD;
        return SEL_ALL;
    endfunction : exp_sel
    task automatic check_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : check_word
    task automatic check_sel(input sel_lines_t got, input sel_lines_t exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: selects %b expected %b", $time, got, exp);
        end
    endtask : check_sel
    task automatic check_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : check_flag
    task automatic check_count(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            miscompares++;
            $display("Error at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask : check_count
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    // poke raises a second start while busy; it must be ignored
    task automatic write_word(input logic [WORD_W-1:0] w, input logic [1:0] m,
                              input logic t, input logic poke);
        logic [WORD_W-1:0] old;
        logic loaded;
        logic prev_cs;
        int n;
        int cyc;
        old = dac_out;
        loaded = 1'b0;
        prev_cs = 1'b1;
        n = 0;
        cyc = 0;
        @(posedge clk);
        start <= 1'b1;
        word <= w;
        mode <= mode_t'(m);
        tc <= t;
        @(posedge clk);
        start <= poke;
        word <= ~w;
        do begin
            @(posedge clk);
            start <= 1'b0;
            cyc++;
            #1;
            if (done !== 1'b1) check_flag(busy, 1'b1);
            if (cs_n === 1'b0 && prev_cs === 1'b1) begin
                check_sel(sel, exp_sel(m, n));
                n++;
            end
            prev_cs = cs_n;
            if (sel.second_rank_load_n === 1'b0) loaded = 1'b1;
            if (!loaded) check_word(dac_out, old);
        end while (done !== 1'b1 && cyc < 40);
        check_count(cyc, (m == 2'b00) ? 21 : (m == 2'b01) ? 11 : 6);
        check_count(n, (m == 2'b00) ? 4 : (m == 2'b01) ? 2 : 1);
        check_flag(busy, 1'b0);
        check_word(data, exp_val(w, t));
        check_word(dac_out, exp_val(w, t));
        repeat (3) @(posedge clk);
        #1;
        check_word(dac_out, exp_val(w, t));
        check_flag(done, 1'b0);
        $display("test done: word %h mode %0d twos %0d", w, m, t);
    endtask : write_word
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check_word(data, WORD_RST);
        check_sel(sel, SEL_NONE);
        check_flag(cs_n, 1'b1);
        check_flag(busy, 1'b0);
        // boundary codes, every mode including the unused encoding
        for (int i = 0; i < 4; i++) begin
            r = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : (i == 2) ? 12'h800 : 12'h7FF;
            write_word(r[11:0], i[1:0], i[0], i == 2);
        end
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            write_word(r[11:0], r[13:12], r[14], r[15]);
        end
        give_verdict();
    end
    // about 30 writes of at most 30 cycles each; generous margin
    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end
endmodule : double_buffered_dac_latch_tb
